// ---- hdl/phy_regs_consts.svh ----
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_EXPANSION     5'h06
`define REG_NP_TX         5'h07
`define REG_LP_NP_RX      5'h08
`define REG_CONFIG        5'h10

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define NP_TX_RESET       16'h2001
`define NP_TX_WMASK       16'hb7ff
`define LP_NP_RX_RESET    16'h0000
`define CONFIG_RESET      16'h0080
`define CONFIG_WMASK      16'h77a2
`define NP_ABLE_LOCAL     1'b1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EXP_BASE_PAGE     5
`define EXP_PD_FAULT      4
`define EXP_LP_NP_ABLE    3
`define EXP_NP_ABLE       2
`define EXP_PAGE_RX       1
`define EXP_LP_AN_ABLE    0
`define NP_NEXT           15
`define NP_RSVD           14
`define NP_MSG            13
`define NP_ACK2           12
`define NP_TOGGLE         11
`define CFG_TX_DIS        13
`define CFG_SCR_BYP       12
`define CFG_JAB_DIS       10
`define CFG_SQE           9
`define CFG_LB_DIS        8
`define CFG_CRS_EXT       7
`define CFG_PRE_PASS      5
`define CFG_ALT_NP        1

// ----------------------------------------
// Management frame counts and field codes
// ----------------------------------------
`define PREAMBLE_BITS     6'd32
`define HDR_LAST          4'd13
`define TA_LAST           1'b1
`define DATA_LAST         4'd15
`define FRAME_START       2'b01
`define OP_READ           2'b10
`define OP_WRITE          2'b01

`endif

// ---- hdl/phy_regs_pkg.sv ----
package phy_regs_pkg;

	// ----------------------------------------
	// Management frame states
	// ----------------------------------------
	typedef enum logic [1:0] {
		MGMT_PRE  = 2'b00,
		MGMT_HDR  = 2'b01,
		MGMT_TA   = 2'b11,
		MGMT_DATA = 2'b10
	} mgmt_state_t;

	// ----------------------------------------
	// Negotiation status from the arbitration logic
	// ----------------------------------------
	typedef struct packed {
		logic        page_rx_pulse;
		logic        page_is_next;
		logic [15:0] rx_code_word;
		logic        mr_page_rx;
		logic        base_page;
		logic        parallel_fault;
		logic        partner_np_able;
		logic        partner_an_able;
		logic        np_tx_sent;
	} an_status_t;

	// ----------------------------------------
	// Receive path status
	// ----------------------------------------
	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic crs_raw;
		logic sfd_dv;
	} rx_path_t;

	// ----------------------------------------
	// Controls toward the line logic
	// ----------------------------------------
	typedef struct packed {
		logic tx_enable;
		logic scrambler_bypass;
		logic jabber_enable;
		logic heartbeat_enable;
		logic loopback_enable;
		logic preamble_pass;
		logic alternate_next_page_enable;
	} phy_ctrl_t;

endpackage : phy_regs_pkg

// ---- hdl/phy_next_page_and_config_regs.sv ----
`timescale 1ns/100ps
`include "phy_regs_consts.svh"

module phy_next_page_and_config_regs
	import phy_regs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output      logic        mdio_o,
	output      logic        mdio_oe_o,
	input  wire logic [4:0]  phy_addr_i,
	input  wire an_status_t  an_i,
	input  wire rx_path_t    rx_i,
	output      phy_ctrl_t   ctrl_o,
	output      logic        crs_o,
	output      logic        rx_dv_o,
	output      logic [15:0] np_tx_word_o,
	output      logic [15:0] partner_base_page_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic        mdc_s1, mdc_s2, mdc_s3;
	logic        mdio_s1, mdio_s2;
	logic [4:0]  addr_s1, addr_s2;
	logic        mdc_rise;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mdc_s1  <= 1'b0;
			mdc_s2  <= 1'b0;
			mdc_s3  <= 1'b0;
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
			addr_s1 <= 5'h00;
			addr_s2 <= 5'h00;
		end else begin
			mdc_s1  <= mdc_i;
			mdc_s2  <= mdc_s1;
			mdc_s3  <= mdc_s2;
			mdio_s1 <= mdio_i;
			mdio_s2 <= mdio_s1;
			addr_s1 <= phy_addr_i;
			addr_s2 <= addr_s1;
		end
	end

	assign mdc_rise = mdc_s2 & ~mdc_s3;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] np_tx_reg;
	logic [15:0] lp_np_rx_reg;
	logic [15:0] config_reg;
	logic [15:0] lp_base_reg;
	logic        base_page_reg;
	logic        pd_fault_reg;
	logic        page_rx_reg;
	logic        alt_np;

	assign alt_np = config_reg[`CFG_ALT_NP];

	// ----------------------------------------
	// Management frame engine
	// ----------------------------------------
	mgmt_state_t state_reg;
	logic [5:0]  pre_cnt_reg;
	logic [3:0]  bit_cnt_reg;
	logic [13:0] hdr_reg;
	logic [15:0] shift_reg;
	logic        is_read_reg;
	logic        match_reg;
	logic [4:0]  reg_addr_reg;
	logic [13:0] hdr_full;
	logic        hdr_ok;
	logic        exp_read;
	logic        wr_commit;
	logic [15:0] wr_data;
	logic [15:0] rd_word;

	assign hdr_full = {hdr_reg[12:0], mdio_s2};
	assign hdr_ok   = (hdr_full[13:12] == `FRAME_START) && (hdr_full[9:5] == addr_s2)
	                  && ((hdr_full[11:10] == `OP_READ) || (hdr_full[11:10] == `OP_WRITE));
	assign exp_read = mdc_rise && (state_reg == MGMT_HDR) && (bit_cnt_reg == `HDR_LAST)
	                  && hdr_ok && (hdr_full[11:10] == `OP_READ)
	                  && (hdr_full[4:0] == `REG_EXPANSION);
	assign wr_data  = {shift_reg[14:0], mdio_s2};
	assign wr_commit = mdc_rise && (state_reg == MGMT_DATA) && (bit_cnt_reg == `DATA_LAST)
	                   && match_reg && !is_read_reg;

	always_comb begin
		rd_word = 16'h0000;
		case (hdr_full[4:0])
			`REG_EXPANSION: begin
				rd_word[`EXP_BASE_PAGE]  = base_page_reg;
				rd_word[`EXP_PD_FAULT]   = pd_fault_reg;
				rd_word[`EXP_LP_NP_ABLE] = an_i.partner_np_able;
				rd_word[`EXP_NP_ABLE]    = `NP_ABLE_LOCAL;
				rd_word[`EXP_PAGE_RX]    = page_rx_reg;
				rd_word[`EXP_LP_AN_ABLE] = an_i.partner_an_able;
			end
			`REG_NP_TX:    rd_word = np_tx_reg;
			`REG_LP_NP_RX: rd_word = lp_np_rx_reg;
			`REG_CONFIG:   rd_word = config_reg & `CONFIG_WMASK;
			default:       rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg    <= MGMT_PRE;
			pre_cnt_reg  <= 6'd0;
			bit_cnt_reg  <= 4'd0;
			hdr_reg      <= 14'h0000;
			is_read_reg  <= 1'b0;
			match_reg    <= 1'b0;
			reg_addr_reg <= 5'h00;
		end else if (mdc_rise) begin
			case (state_reg)
				MGMT_PRE: begin
					if (mdio_s2) begin
						if (pre_cnt_reg != `PREAMBLE_BITS)
							pre_cnt_reg <= pre_cnt_reg + 6'd1;
					end else begin
						pre_cnt_reg <= 6'd0;
						if (pre_cnt_reg == `PREAMBLE_BITS) begin
							state_reg   <= MGMT_HDR;
							hdr_reg     <= 14'h0000;
							bit_cnt_reg <= 4'd1;
						end
					end
				end
				MGMT_HDR: begin
					hdr_reg     <= hdr_full;
					bit_cnt_reg <= bit_cnt_reg + 4'd1;
					if (bit_cnt_reg == `HDR_LAST) begin
						state_reg    <= MGMT_TA;
						bit_cnt_reg  <= 4'd0;
						match_reg    <= hdr_ok;
						is_read_reg  <= (hdr_full[11:10] == `OP_READ);
						reg_addr_reg <= hdr_full[4:0];
					end
				end
				MGMT_TA: begin
					bit_cnt_reg <= bit_cnt_reg + 4'd1;
					if (bit_cnt_reg[0] == `TA_LAST) begin
						state_reg   <= MGMT_DATA;
						bit_cnt_reg <= 4'd0;
					end
				end
				MGMT_DATA: begin
					bit_cnt_reg <= bit_cnt_reg + 4'd1;
					if (bit_cnt_reg == `DATA_LAST) begin
						state_reg   <= MGMT_PRE;
						bit_cnt_reg <= 4'd0;
					end
				end
				default: state_reg <= MGMT_PRE;
			endcase
		end
	end

	// ----------------------------------------
	// Serial data shifter and pin drive
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			shift_reg <= 16'h0000;
			mdio_o    <= 1'b1;
			mdio_oe_o <= 1'b0;
		end else if (mdc_rise) begin
			case (state_reg)
				MGMT_HDR: begin
					if (bit_cnt_reg == `HDR_LAST)
						shift_reg <= rd_word;
				end
				MGMT_TA: begin
					if (match_reg && is_read_reg) begin
						mdio_oe_o <= 1'b1;
						mdio_o    <= (bit_cnt_reg[0] == `TA_LAST) ? shift_reg[15] : 1'b0;
					end
				end
				MGMT_DATA: begin
					if (is_read_reg) begin
						shift_reg <= {shift_reg[14:0], 1'b0};
						mdio_o    <= shift_reg[14];
						if (bit_cnt_reg == `DATA_LAST) begin
							mdio_oe_o <= 1'b0;
							mdio_o    <= 1'b1;
						end
					end else begin
						shift_reg <= wr_data;
					end
				end
				default: begin
					mdio_oe_o <= 1'b0;
					mdio_o    <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			config_reg <= `CONFIG_RESET;
		end else if (wr_commit && reg_addr_reg == `REG_CONFIG) begin
			config_reg <= wr_data & `CONFIG_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			np_tx_reg <= `NP_TX_RESET;
		end else begin
			if (wr_commit && reg_addr_reg == `REG_NP_TX)
				np_tx_reg <= (wr_data & `NP_TX_WMASK) | (np_tx_reg & ~`NP_TX_WMASK);
			if (an_i.np_tx_sent)
				np_tx_reg[`NP_TOGGLE] <= ~np_tx_reg[`NP_TOGGLE];
		end
	end

	// ----------------------------------------
	// Received pages and latching flags
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lp_np_rx_reg <= `LP_NP_RX_RESET;
			lp_base_reg  <= 16'h0000;
		end else if (an_i.page_rx_pulse) begin
			if (an_i.page_is_next)
				lp_np_rx_reg <= an_i.rx_code_word;
			else
				lp_base_reg <= an_i.rx_code_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			page_rx_reg <= 1'b0;
		end else if (an_i.page_rx_pulse) begin
			page_rx_reg <= 1'b1;
		end else if (exp_read) begin
			page_rx_reg <= 1'b0;
		end else if (alt_np && (!an_i.mr_page_rx || config_reg[`CFG_TX_DIS])) begin
			page_rx_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pd_fault_reg  <= 1'b0;
			base_page_reg <= 1'b0;
		end else begin
			if (an_i.parallel_fault)
				pd_fault_reg <= 1'b1;
			else if (exp_read)
				pd_fault_reg <= 1'b0;
			if (alt_np && an_i.base_page)
				base_page_reg <= 1'b1;
			else if (exp_read)
				base_page_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Line controls and receive path
	// ----------------------------------------
	logic rx_dv_next;

	assign rx_dv_next = config_reg[`CFG_PRE_PASS] ? rx_i.crs_raw : rx_i.sfd_dv;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_o              <= '0;
			crs_o               <= 1'b0;
			rx_dv_o             <= 1'b0;
			np_tx_word_o        <= `NP_TX_RESET;
			partner_base_page_o <= 16'h0000;
		end else begin
			ctrl_o.tx_enable        <= ~config_reg[`CFG_TX_DIS];
			ctrl_o.scrambler_bypass <= config_reg[`CFG_SCR_BYP] & rx_i.speed_100;
			ctrl_o.jabber_enable    <= ~(config_reg[`CFG_JAB_DIS] & ~rx_i.speed_100);
			ctrl_o.heartbeat_enable <= config_reg[`CFG_SQE] & ~rx_i.speed_100;
			ctrl_o.loopback_enable  <= ~(config_reg[`CFG_LB_DIS] & ~rx_i.speed_100
			                             & ~rx_i.full_duplex);
			ctrl_o.preamble_pass    <= config_reg[`CFG_PRE_PASS];
			ctrl_o.alternate_next_page_enable <= alt_np;
			rx_dv_o <= rx_dv_next;
			crs_o   <= rx_i.crs_raw | (config_reg[`CFG_CRS_EXT] & ~rx_i.speed_100
			                           & crs_o & rx_dv_next);
			np_tx_word_o        <= np_tx_reg;
			partner_base_page_o <= lp_base_reg;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_page_in;
		an_i.page_rx_pulse;
	endsequence

	property p_page_set;
		s_page_in |=> page_rx_reg;
	endproperty
	a_page_set: assert property (p_page_set) else $error("page flag not set");

	property p_read_clear;
		exp_read && !an_i.page_rx_pulse |=> !page_rx_reg;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("page flag not cleared");

	property p_alt_clear;
		alt_np && !an_i.mr_page_rx && !an_i.page_rx_pulse |=> !page_rx_reg;
	endproperty
	a_alt_clear: assert property (p_alt_clear) else $error("alt clear missed");

	property p_fault_hold;
		pd_fault_reg && !exp_read |=> pd_fault_reg;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped");

	property p_base_gate;
		!alt_np && !base_page_reg |=> !base_page_reg;
	endproperty
	a_base_gate: assert property (p_base_gate) else $error("base flag without option");

	property p_rsvd_zero;
		!np_tx_reg[`NP_RSVD] && !np_tx_word_o[`NP_RSVD];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

	property p_toggle;
		an_i.np_tx_sent && !wr_commit |=> np_tx_reg[`NP_TOGGLE] != $past(np_tx_reg[`NP_TOGGLE]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle not flipped");

	property p_tx_dis;
		config_reg[`CFG_TX_DIS] ##1 config_reg[`CFG_TX_DIS] |-> !ctrl_o.tx_enable;
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("transmitter on while disabled");

	property p_scr_10;
		!rx_i.speed_100 |=> !ctrl_o.scrambler_bypass;
	endproperty
	a_scr_10: assert property (p_scr_10) else $error("bypass in 10 Mb/s");

	property p_read_drive;
		mdc_rise && state_reg == MGMT_TA && match_reg && is_read_reg |=> mdio_oe_o;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");

	property p_rxdv_pre;
		config_reg[`CFG_PRE_PASS] && rx_i.crs_raw |=> rx_dv_o;
	endproperty
	a_rxdv_pre: assert property (p_rxdv_pre) else $error("preamble pass late");

endmodule : phy_next_page_and_config_regs

// ---- tb/mgmt_host_model.sv ----
`timescale 1ns/100ps
module mgmt_host_model (
	input  wire logic clk_i,
	input  wire logic mdio_i,
	output      logic mdc_o,
	output      logic mdio_o,
	output      logic mdio_oe_o
);
	initial begin
		mdc_o     = 1'b0;
		mdio_o    = 1'b1;
		mdio_oe_o = 1'b0;
	end

	// ----------------------------------------
	// One bit: drive in low phase, sample at the rise
	// ----------------------------------------
	task automatic mgmt_bit(input logic oe, input logic v, output logic s);
		@(posedge clk_i);
		#1;
		mdc_o     = 1'b0;
		mdio_oe_o = oe;
		mdio_o    = v;
		repeat (8) @(posedge clk_i);
		#1;
		s     = mdio_i;
		mdc_o = 1'b1;
		repeat (7) @(posedge clk_i);
	endtask : mgmt_bit

	// ----------------------------------------
	// Whole frame; the clock stands low afterwards
	// ----------------------------------------
	task automatic mgmt_frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd, output logic ta2);
		logic [13:0] hdr;
		logic        s;
		logic        wr;
		int          i;
		hdr = {2'b01, op, pa, ra};
		wr  = (op == 2'b01);
		for (i = 0; i < 32; i++) begin
			mgmt_bit(1'b1, 1'b1, s);
		end
		for (i = 13; i >= 0; i--) begin
			mgmt_bit(1'b1, hdr[i], s);
		end
		mgmt_bit(wr, 1'b1, s);
		mgmt_bit(wr, 1'b0, ta2);
		for (i = 15; i >= 0; i--) begin
			mgmt_bit(wr, wd[i], s);
			rd[i] = s;
		end
		@(posedge clk_i);
		#1;
		mdc_o     = 1'b0;
		mdio_oe_o = 1'b0;
	endtask : mgmt_frame
endmodule : mgmt_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
	import phy_regs_pkg::*;
();
	logic        clk = 1'b0;
	logic        srst;
	logic        mdc;
	logic        host_do;
	logic        host_oe;
	logic        dut_do;
	logic        dut_oe;
	logic        mdio_wire;
	logic [4:0]  phy_addr;
	an_status_t  an;
	rx_path_t    rx;
	phy_ctrl_t   ctrl;
	logic        crs;
	logic        rx_dv;
	logic [15:0] np_word;
	logic [15:0] base_word;
	int          err_count = 0;
	int          n_checks = 0;

	always #4 clk = ~clk;

	// Pull-up on the shared data line
	assign mdio_wire = dut_oe ? dut_do : (host_oe ? host_do : 1'b1);

	phy_next_page_and_config_regs u_phy_next_page_and_config_regs (
		.clk_i               (clk),
		.srst_i              (srst),
		.mdc_i               (mdc),
		.mdio_i              (mdio_wire),
		.mdio_o              (dut_do),
		.mdio_oe_o           (dut_oe),
		.phy_addr_i          (phy_addr),
		.an_i                (an),
		.rx_i                (rx),
		.ctrl_o              (ctrl),
		.crs_o               (crs),
		.rx_dv_o             (rx_dv),
		.np_tx_word_o        (np_word),
		.partner_base_page_o (base_word)
	);

	mgmt_host_model u_mgmt_host_model (
		.clk_i     (clk),
		.mdio_i    (mdio_wire),
		.mdc_o     (mdc),
		.mdio_o    (host_do),
		.mdio_oe_o (host_oe)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic rchk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp,
		input string what);
		logic [15:0] d;
		logic        t;
		u_mgmt_host_model.mgmt_frame(2'b10, pa, ra, 16'h0000, d, t);
		chk(what, d, exp);
		chk("turnaround", {15'h0000, t}, {15'h0000, pa != phy_addr});
	endtask : rchk

	task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] d;
		logic        t;
		u_mgmt_host_model.mgmt_frame(2'b01, pa, ra, wd, d, t);
	endtask : wr

	task automatic page(input logic nxt, input logic [15:0] w, input logic bp, input logic pf);
		an.page_rx_pulse  = 1'b1;
		an.page_is_next   = nxt;
		an.rx_code_word   = w;
		an.base_page      = bp;
		an.parallel_fault = pf;
		step(1);
		an.page_rx_pulse  = 1'b0;
		an.base_page      = 1'b0;
		an.parallel_fault = 1'b0;
		step(2);
	endtask : page

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		an       = '0;
		rx       = '0;
		srst     = 1'b1;
		phy_addr = 5'h05;
		step(10);
		srst = 1'b0;
		step(1);
		chk("ctrl_reset", {9'h000, ctrl}, 16'h0054);
		chk("np_word_reset", np_word, 16'h2001);
		chk("base_word_reset", base_word, 16'h0000);
		step(3);
		rchk(phy_addr, 5'h06, 16'h0004, "expansion_reset");
		rchk(phy_addr, 5'h07, 16'h2001, "np_tx_reset");
		rchk(phy_addr, 5'h08, 16'h0000, "lp_np_reset");
		rchk(phy_addr, 5'h10, 16'h0080, "config_reset");

		rx.crs_raw = 1'b1;
		step(2);
		chk("rx_dv_no_sfd", {15'h0000, rx_dv}, 16'h0000);
		rx.sfd_dv = 1'b1;
		step(2);
		chk("rx_dv_sfd", {15'h0000, rx_dv}, 16'h0001);
		rx.crs_raw = 1'b0;
		step(3);
		chk("crs_held", {15'h0000, crs}, 16'h0001);
		rx.sfd_dv = 1'b0;
		step(2);
		chk("crs_released", {15'h0000, crs}, 16'h0000);

		wr(phy_addr, 5'h07, 16'hbfff);
		rchk(phy_addr, 5'h07, 16'hb7ff, "np_tx_rw");
		chk("np_word", np_word, 16'hb7ff);
		wr(phy_addr, 5'h07, 16'h0000);
		an.np_tx_sent = 1'b1;
		step(1);
		an.np_tx_sent = 1'b0;
		rchk(phy_addr, 5'h07, 16'h0800, "np_toggle");

		an.partner_np_able = 1'b1;
		an.partner_an_able = 1'b1;
		an.mr_page_rx      = 1'b1;
		page(1'b1, 16'ha5c3, 1'b1, 1'b1);
		rchk(phy_addr, 5'h06, 16'h001f, "expansion_set");
		rchk(phy_addr, 5'h06, 16'h000d, "expansion_clr");
		rchk(phy_addr, 5'h08, 16'ha5c3, "lp_np_word");
		page(1'b0, 16'h1234, 1'b0, 1'b0);
		chk("base_word", base_word, 16'h1234);
		rchk(phy_addr, 5'h06, 16'h000f, "base_page_rx");

		wr(5'h06, 5'h07, 16'h8000);
		rchk(phy_addr, 5'h07, 16'h0800, "wrong_addr_write");
		rchk(5'h06, 5'h06, 16'hffff, "wrong_addr_read");
		rchk(phy_addr, 5'h09, 16'h0000, "unmapped");

		wr(phy_addr, 5'h10, 16'h77a2);
		rchk(phy_addr, 5'h10, 16'h77a2, "config_rw");
		chk("ctrl_10m", {9'h000, ctrl}, 16'h000b);
		rx.speed_100 = 1'b1;
		step(2);
		chk("scrambler_100m", {15'h0000, ctrl.scrambler_bypass}, 16'h0001);
		chk("ctrl_100m", {9'h000, ctrl}, 16'h0037);
		rx.speed_100   = 1'b0;
		rx.full_duplex = 1'b1;
		step(2);
		chk("ctrl_10m_fdx", {9'h000, ctrl}, 16'h000f);
		rx.full_duplex = 1'b0;
		rx.crs_raw   = 1'b1;
		step(2);
		chk("rx_dv_preamble", {15'h0000, rx_dv}, 16'h0001);
		rx.crs_raw = 1'b0;
		step(2);
		chk("rx_dv_end", {15'h0000, rx_dv}, 16'h0000);

		page(1'b1, 16'h0f0f, 1'b1, 1'b0);
		rchk(phy_addr, 5'h06, 16'h002d, "alt_tx_dis");
		rchk(phy_addr, 5'h06, 16'h000d, "alt_clr");
		rchk(phy_addr, 5'h08, 16'h0f0f, "lp_np_word2");
		wr(phy_addr, 5'h10, 16'h0002);
		an.mr_page_rx = 1'b0;
		page(1'b1, 16'h0f0f, 1'b0, 1'b0);
		rchk(phy_addr, 5'h06, 16'h000d, "alt_mr_low");
		an.mr_page_rx = 1'b1;
		page(1'b1, 16'h0f0f, 1'b0, 1'b0);
		rchk(phy_addr, 5'h06, 16'h000f, "alt_mr_high");
		close_out();
	end
endmodule : tb_top
